// ===== osmc_pkg.sv
// Shared constants and types for the option slot mask control block
package osmc_pkg;

	localparam int          OSMC_IMG_W     = 24;          // Control and feedback image width
	localparam int          OSMC_BYTE_W    = 8;           // One image byte
	localparam int          OSMC_NBYTE     = 3;           // Bytes per image
	localparam int          OSMC_NSLOT     = 16;          // Module slots 2 to 17
	localparam int          OSMC_SLOT_LO   = 2;           // First module slot bit
	localparam int          OSMC_SLOT_HI   = 17;          // Last module slot bit
	localparam int          OSMC_VALID0    = 0;           // First validity bit
	localparam int          OSMC_VALID1    = 1;           // Second validity bit
	localparam int          OSMC_SLOT_W    = 5;           // Slot number width
	localparam int          OSMC_CNT_W     = 5;           // Module count width
	localparam int          OSMC_PAD_W     = OSMC_IMG_W - OSMC_SLOT_HI - 1; // Unused top bits
	localparam logic [4:0]  OSMC_SLOT_LO_N = 5'h02;       // First module slot number
	localparam logic [4:0]  OSMC_SLOT_HI_N = 5'h11;       // Last module slot number
	localparam logic [15:0] OSMC_ERR_ABSENT = 16'h80b2;   // Answer for an absent slot
	localparam logic [15:0] OSMC_ERR_NONE  = 16'h0000;    // Answer for a present slot
	localparam logic [23:0] OSMC_IMG_RST   = 24'h000000;  // Image reset value
	localparam logic [15:0] OSMC_SLOT_RST  = 16'h0000;    // Slot mask reset value
	localparam logic [15:0] OSMC_SLOT_ALL  = 16'hffff;    // Every slot set

	// Station operating state
	typedef enum logic [2:0] {
		OSMC_ST_BOOT,   // One cycle after reset, picks first or warm start
		OSMC_ST_WAIT,   // Exchanging, waiting for option data
		OSMC_ST_RUN,    // I/O enabled
		OSMC_ST_HOLD,   // Mismatch tolerated, I/O off
		OSMC_ST_BLOCK   // Mismatch not tolerated, station not started
	} osmc_state_e;

endpackage : osmc_pkg

// ===== osmc_popcount.sv
// Counts the set bits of a slot mask
`timescale 1ns/1ps
module osmc_popcount #(
	parameter int W  = 16,  // Mask width
	parameter int CW = 5    // Count width
) (
	input  wire logic [W-1:0]  bits_i,   // Mask to count
	output logic      [CW-1:0] count_o   // Number of ones
);

	// Plain adder chain; sixteen bits keep it shallow enough at this rate
	always_comb begin
		count_o = '0;
		for (int k = 0; k < W; k++) begin
			count_o = count_o + CW'(bits_i[k]);
		end
	end

endmodule : osmc_popcount

// ===== osmc_thermo.sv
// Turns a count into a gapless run of ones from bit 0
`timescale 1ns/1ps
module osmc_thermo #(
	parameter int W  = 16,  // Output width
	parameter int CW = 5    // Count width
) (
	input  wire logic [CW-1:0] count_i,  // Number of ones wanted
	output logic      [W-1:0]  thermo_o  // Ones in the low count bits
);

	// One comparator per output bit
	for (genvar k = 0; k < W; k++) begin : g_bit
		assign thermo_o[k] = (count_i > CW'(k));
	end

endmodule : osmc_thermo

// ===== osmc_top.sv
// Option slot mask control: control image, feedback image, startup and faults
//
// Function
// [RULE1] One control and feedback bit per slot 2-17
// [RULE2] Ignore control image unless slot 0,1 bits set
// [RULE3] Slot bit 0 absent, 1 present
// [RULE4] Feedback bits 0,1 show control active
// [RULE5] Feedback slot bit: available and OK only
// [RULE6] Feedback is three bytes, ascending slot order
// [RULE7] No configuration check before valid presence data
// [RULE8] Master sets both validity bits to start
// [RULE9] Master writes first control byte last
// [RULE10] Or master sets validity bit next cycle
// [RULE11] Any control byte change is captured, applied
// [RULE12] First startup: exchange, I/O off until valid
// [RULE13] Waiting: bus fault off, module faults lit
// [RULE14] Retain option data; warm restart enables at once
// [RULE15] Mismatch disables I/O until configuration matches
// [RULE16] No mismatch mode: block, diagnose, fault, substitutes
// [RULE17] No master: report modules gapless from one
// [RULE18] Overflow beyond slot 17: diag, status, fault
// [RULE19] Access to absent slot answers 80B2
// [RULE20] Configured slot numbers always used for addressing
// [RULE21] Master trusts feedback only if equal to control
// [RULE22] Feedback refreshed on every exchange cycle
`timescale 1ns/1ps
module osmc_top
	import osmc_pkg::*;
(
	input  wire logic                      CLOCK_I,              // Station clock, 20 MHz
	input  wire logic                      RST_I,                // Warm restart, sync high
	input  wire logic                      POR_I,                // Power-on, clears retention
	input  wire logic                      CTRL_WR_I,            // Single control byte write
	input  wire logic [1:0]                CTRL_ADDR_I,          // Byte index of that write
	input  wire logic [OSMC_BYTE_W-1:0]    CTRL_DATA_I,          // Byte written
	input  wire logic                      CTRL_WR_ALL_I,        // Consistent three-byte write
	input  wire logic [OSMC_IMG_W-1:0]     CTRL_IMAGE_I,         // Image for that write
	input  wire logic                      EXCH_CYCLE_I,         // Data exchange cycle strobe
	input  wire logic                      HOST_ONLINE_I,        // Master present, configured
	input  wire logic                      MISMATCH_OP_EN_I,     // Operate on mismatch enabled
	input  wire logic [OSMC_NSLOT-1:0]     MOD_AVAIL_I,          // Module plugged per slot
	input  wire logic [OSMC_NSLOT-1:0]     MOD_OK_I,             // Module status OK per slot
	input  wire logic [OSMC_NSLOT-1:0]     MOD_WRONG_I,          // Wrong module type per slot
	input  wire logic                      ACC_REQ_I,            // Instruction access to a slot
	input  wire logic [OSMC_SLOT_W-1:0]    ACC_SLOT_I,           // Configured slot number
	output logic      [OSMC_IMG_W-1:0]     FEEDBACK_O,           // Feedback image
	output logic      [OSMC_IMG_W-1:0]     CTRL_IMAGE_O,         // Control image readback
	output logic                           IO_EN_O,              // Module I/O enabled
	output logic                           SUBST_O,              // Substitute values output
	output logic                           DIAG_NO_MODULE_O,     // Missing module diagnostic
	output logic                           DIAG_WRONG_MODULE_O,  // Wrong module diagnostic
	output logic                           DIAG_ID_TOP_O,        // Identifier diag top bit
	output logic                           STATUS1_BIT3_O,       // External diagnostics flag
	output logic                           MOD_FAULT_LED_O,      // Station fault indicator
	output logic                           BUS_FAULT_LED_O,      // Bus fault indicator
	output logic      [OSMC_NSLOT-1:0]     SLOT_FAULT_LED_O,     // Per-module fault indicators
	output logic                           ACC_DONE_O,           // Access answered, pulse
	output logic                           ACC_ERR_O,            // Access refused
	output logic      [15:0]               ACC_CODE_O            // Access answer code
);

	import osmc_pkg::*;

	// Control image, held across warm restarts only by the master rewriting it
	logic [OSMC_IMG_W-1:0] ctrl_reg;        // Current control image
	logic [OSMC_IMG_W-1:0] ctrl_next;       // Image after this cycle's writes
	logic [OSMC_NSLOT-1:0] ret_img_reg;     // Retained presence mask
	logic                  ret_valid_reg;   // Retained mask is valid
	osmc_state_e           state_reg;       // Operating state
	osmc_state_e           state_next;      // Next operating state
	logic [OSMC_IMG_W-1:0] fb_reg;          // Feedback image
	logic                  io_en_reg;       // Registered I/O enable
	logic                  subst_reg;       // Registered substitute flag
	logic                  no_mod_reg;      // Missing module diagnostic
	logic                  wrong_mod_reg;   // Wrong module diagnostic
	logic                  ovf_reg;         // Overflow diagnostic
	logic                  mod_led_reg;     // Station fault LED
	logic                  bus_led_reg;     // Bus fault LED
	logic [OSMC_NSLOT-1:0] slot_led_reg;    // Per-module LEDs
	logic                  acc_done_reg;    // Access answer strobe
	logic                  acc_err_reg;     // Access error
	logic [15:0]           acc_code_reg;    // Access answer code

	// Byte merge: a consistent write wins over a single byte write
	// Byte index 3 matches no generate branch and so changes nothing
	for (genvar b = 0; b < OSMC_NBYTE; b++) begin : g_byte
		wire byte_hit = CTRL_WR_I && (CTRL_ADDR_I == 2'(b));
		assign ctrl_next[b*OSMC_BYTE_W +: OSMC_BYTE_W] =
			CTRL_WR_ALL_I ? CTRL_IMAGE_I[b*OSMC_BYTE_W +: OSMC_BYTE_W] :
			byte_hit      ? CTRL_DATA_I :
			                ctrl_reg[b*OSMC_BYTE_W +: OSMC_BYTE_W]; // RULE11
	end

	// Validity and the presence mask in force
	wire                  ctrl_valid  = ctrl_reg[OSMC_VALID0] & ctrl_reg[OSMC_VALID1]; // RULE2
	wire                  next_valid  = ctrl_next[OSMC_VALID0] & ctrl_next[OSMC_VALID1];
	wire                  ctrl_change = (ctrl_next != ctrl_reg);
	wire [OSMC_NSLOT-1:0] ctrl_slots  = ctrl_reg[OSMC_SLOT_HI:OSMC_SLOT_LO]; // RULE1
	// A valid image from the master overrides the retained one
	wire [OSMC_NSLOT-1:0] eff_present = ctrl_valid ? ctrl_slots : ret_img_reg; // RULE3
	wire                  info_valid  = ctrl_valid | ret_valid_reg;

	// Module counts for overflow and the gapless wiring-test view
	logic [OSMC_CNT_W-1:0] avail_cnt;       // Plugged modules
	logic [OSMC_CNT_W-1:0] present_cnt;     // Slots marked present
	logic [OSMC_NSLOT-1:0] gapless;         // Plugged modules packed from slot 2 up

	osmc_popcount #(.W(OSMC_NSLOT), .CW(OSMC_CNT_W)) u_cnt_avail (
		.bits_i  (MOD_AVAIL_I),
		.count_o (avail_cnt)
	);

	osmc_popcount #(.W(OSMC_NSLOT), .CW(OSMC_CNT_W)) u_cnt_present (
		.bits_i  (eff_present),
		.count_o (present_cnt)
	);

	osmc_thermo #(.W(OSMC_NSLOT), .CW(OSMC_CNT_W)) u_gapless (
		.count_i  (avail_cnt),
		.thermo_o (gapless)
	);

	// More plugged modules than present slots pushes some past the last slot.
	// Only the counts are compared: the slot that lands past the end is not
	// named, which is all that the identifier diagnostics can carry anyway.
	wire overflow = info_valid & (avail_cnt > present_cnt); // RULE18
	// Checks against the master configuration only mean something with valid data
	wire missing  = info_valid & (|(eff_present & ~MOD_AVAIL_I)); // RULE7
	wire wrong    = info_valid & (|(eff_present & MOD_WRONG_I));
	wire extra    = info_valid & (|(~eff_present & MOD_AVAIL_I));
	wire mismatch = missing | wrong | extra | overflow; // RULE15
	wire fail_st  = MISMATCH_OP_EN_I;
	// Verdict for the current inputs: run, tolerate the mismatch, or refuse
	osmc_state_e eval_st;
	assign eval_st = !mismatch ? OSMC_ST_RUN : fail_st ? OSMC_ST_HOLD : OSMC_ST_BLOCK;

	// State transitions
	// Every state but BLOCK decides from the same eval_st term, so a plugged set that
	// changes while a decision is pending cannot leave two paths disagreeing.
	// BLOCK is left only on a full match; turning on operate-on-mismatch alone
	// does not release a station that was refused.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			OSMC_ST_BOOT: begin
				// Warm restart with retained data goes straight to checking
				state_next = ret_valid_reg ? eval_st : OSMC_ST_WAIT; // RULE14
			end
			OSMC_ST_WAIT: begin
				if (ctrl_valid) begin
					state_next = eval_st; // RULE12
				end
			end
			OSMC_ST_RUN: begin
				if (mismatch) begin
					state_next = eval_st; // RULE15
				end
			end
			OSMC_ST_HOLD: begin
				// Leaves for RUN when the plugged set agrees again, for BLOCK if mismatch is no longer tolerated
				state_next = eval_st; // RULE15
			end
			OSMC_ST_BLOCK: begin
				if (!mismatch) begin
					state_next = OSMC_ST_RUN; // RULE16
				end
			end
			default: begin
				state_next = OSMC_ST_BOOT;
			end
		endcase
	end

	// Output terms ahead of their registers
	// Decoding state_next rather than state_reg saves one cycle of latency
	wire run_next   = (state_next == OSMC_ST_RUN);
	wire block_next = (state_next == OSMC_ST_BLOCK);
	wire wait_next  = (state_next == OSMC_ST_WAIT);
	// While waiting every module shows its fault, bus stays quiet
	wire [OSMC_NSLOT-1:0] slot_led_next =
		run_next ? (MOD_AVAIL_I & ~MOD_OK_I) : OSMC_SLOT_ALL; // RULE13
	wire bus_led_next = ~HOST_ONLINE_I & ~wait_next; // RULE13

	// Feedback: absent slots read 0, no master gives the gapless view
	wire [OSMC_NSLOT-1:0] present_mask = info_valid ? eff_present : OSMC_SLOT_ALL;
	wire [OSMC_NSLOT-1:0] fb_slots =
		HOST_ONLINE_I ? (MOD_AVAIL_I & MOD_OK_I & present_mask) : gapless; // RULE5 RULE17
	wire [OSMC_IMG_W-1:0] fb_next =
		{{OSMC_PAD_W{1'b0}}, fb_slots, info_valid, info_valid}; // RULE4 RULE6

	// Access decode by configured slot number, never by physical position
	// Slots 0 and 1 are the head and its supply and always answer; with no
	// valid option data every slot counts as present and only numbers above 17 are refused
	wire [OSMC_SLOT_W-1:0] acc_off  = ACC_SLOT_I - OSMC_SLOT_LO_N; // RULE20
	wire                   acc_mod  = (ACC_SLOT_I >= OSMC_SLOT_LO_N);
	wire                   acc_over = (ACC_SLOT_I > OSMC_SLOT_HI_N);
	wire                   acc_absent =
		acc_over | (acc_mod & ~present_mask[acc_off[3:0]]); // RULE19

	// Control image register; a warm restart clears it, the master rewrites
	always_ff @(posedge CLOCK_I) begin
		if (RST_I || POR_I) begin
			ctrl_reg <= OSMC_IMG_RST;
		end else begin
			ctrl_reg <= ctrl_next; // RULE11
		end
	end

	// Retentive mask survives warm restart, lost only at power-on
	// Only a changed, valid image is retained, so a master that rewrites the
	// same image every cycle does not churn the retained copy
	always_ff @(posedge CLOCK_I) begin
		if (POR_I) begin
			ret_img_reg   <= OSMC_SLOT_RST;
			ret_valid_reg <= 1'b0;
		end else if (!RST_I && ctrl_change && next_valid) begin
			ret_img_reg   <= ctrl_next[OSMC_SLOT_HI:OSMC_SLOT_LO]; // RULE14
			ret_valid_reg <= 1'b1;
		end
	end

	// Operating state
	always_ff @(posedge CLOCK_I) begin
		if (RST_I || POR_I) begin
			state_reg <= OSMC_ST_BOOT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Feedback only moves on an exchange cycle so the master sees one snapshot.
	// Status changes between strobes are not latched: the next strobe samples the
	// levels as they stand then.
	always_ff @(posedge CLOCK_I) begin
		if (RST_I || POR_I) begin
			fb_reg <= OSMC_IMG_RST;
		end else if (EXCH_CYCLE_I) begin
			fb_reg <= fb_next; // RULE22
		end
	end

	// Station status outputs
	// All but ovf_reg follow state_next so that they turn over on the same edge as the
	// state register, with no extra cycle of stale indication
	always_ff @(posedge CLOCK_I) begin
		if (RST_I || POR_I) begin
			io_en_reg     <= 1'b0;
			subst_reg     <= 1'b1;
			no_mod_reg    <= 1'b0;
			wrong_mod_reg <= 1'b0;
			ovf_reg       <= 1'b0;
			mod_led_reg   <= 1'b0;
			bus_led_reg   <= 1'b0;
			slot_led_reg  <= OSMC_SLOT_ALL;
		end else begin
			io_en_reg     <= run_next; // RULE12
			subst_reg     <= ~run_next; // RULE16
			no_mod_reg    <= block_next & missing; // RULE16
			wrong_mod_reg <= block_next & wrong; // RULE16
			ovf_reg       <= overflow; // RULE18
			mod_led_reg   <= block_next | overflow; // RULE16 RULE18
			bus_led_reg   <= bus_led_next;
			slot_led_reg  <= slot_led_next;
		end
	end

	// Access answers one cycle after the request
	always_ff @(posedge CLOCK_I) begin
		if (RST_I || POR_I) begin
			acc_done_reg <= 1'b0;
			acc_err_reg  <= 1'b0;
			acc_code_reg <= OSMC_ERR_NONE;
		end else begin
			acc_done_reg <= ACC_REQ_I;
			acc_err_reg  <= ACC_REQ_I & acc_absent;
			acc_code_reg <= (ACC_REQ_I & acc_absent) ? OSMC_ERR_ABSENT : OSMC_ERR_NONE; // RULE19
		end
	end

	// Every output is a register; these lines only rename
	assign FEEDBACK_O          = fb_reg;
	assign CTRL_IMAGE_O        = ctrl_reg;
	assign IO_EN_O             = io_en_reg;
	assign SUBST_O             = subst_reg;
	assign DIAG_NO_MODULE_O    = no_mod_reg;
	assign DIAG_WRONG_MODULE_O = wrong_mod_reg;
	assign DIAG_ID_TOP_O       = ovf_reg;
	assign STATUS1_BIT3_O      = ovf_reg;
	assign MOD_FAULT_LED_O     = mod_led_reg;
	assign BUS_FAULT_LED_O     = bus_led_reg;
	assign SLOT_FAULT_LED_O    = slot_led_reg;
	assign ACC_DONE_O          = acc_done_reg;
	assign ACC_ERR_O           = acc_err_reg;
	assign ACC_CODE_O          = acc_code_reg;

	// Checks on the block's own behaviour, off while either reset is held
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I || POR_I);

	fb_active_a: assert property (EXCH_CYCLE_I |=> FEEDBACK_O[1:0] == {2{$past(info_valid)}}) // RULE4
		else $error("feedback validity bits wrong");
	fb_pad_a: assert property (FEEDBACK_O[OSMC_IMG_W-1:OSMC_SLOT_HI+1] == '0) // RULE6
		else $error("feedback top bits not zero");
	fb_not_ok_a: assert property (EXCH_CYCLE_I && HOST_ONLINE_I
		|=> (FEEDBACK_O[OSMC_SLOT_HI:OSMC_SLOT_LO] & ~$past(MOD_AVAIL_I & MOD_OK_I)) == '0) // RULE5
		else $error("feedback set for a faulty module");
	no_info_a: assert property (!info_valid |-> state_next != OSMC_ST_RUN ##1 !IO_EN_O) // RULE7
		else $error("I/O enabled without valid option data");
	wait_leds_a: assert property (state_reg == OSMC_ST_WAIT && !ctrl_valid
		|=> !BUS_FAULT_LED_O && (&SLOT_FAULT_LED_O) && !IO_EN_O) // RULE13
		else $error("wrong indicators while waiting");
	warm_run_a: assert property (state_reg == OSMC_ST_BOOT && ret_valid_reg && !mismatch
		|=> IO_EN_O) // RULE14
		else $error("warm restart did not enable I/O");
	hold_exit_a: assert property (state_reg == OSMC_ST_HOLD && !mismatch
		|=> state_reg == OSMC_ST_RUN && IO_EN_O) // RULE15
		else $error("hold not left on match");
	hold_io_a: assert property (state_reg == OSMC_ST_HOLD |-> !IO_EN_O) // RULE15
		else $error("I/O enabled while holding on mismatch");
	block_subst_a: assert property (state_next == OSMC_ST_BLOCK
		|=> SUBST_O && MOD_FAULT_LED_O && !IO_EN_O) // RULE16
		else $error("blocked station not substituting");
	ovf_diag_a: assert property (overflow |=> DIAG_ID_TOP_O && STATUS1_BIT3_O && MOD_FAULT_LED_O) // RULE18
		else $error("overflow not reported");
	absent_err_a: assert property (ACC_REQ_I && acc_absent
		|=> ACC_DONE_O && ACC_ERR_O && ACC_CODE_O == OSMC_ERR_ABSENT) // RULE19
		else $error("absent slot access not refused");
	acc_ok_a: assert property (ACC_REQ_I && !acc_absent
		|=> ACC_DONE_O && !ACC_ERR_O && ACC_CODE_O == OSMC_ERR_NONE) // RULE19
		else $error("present slot access refused");
	capture_all_a: assert property (CTRL_WR_ALL_I |=> CTRL_IMAGE_O == $past(CTRL_IMAGE_I)) // RULE11
		else $error("consistent write not captured");


	// Main scenarios that the bench is expected to reach
	run_seen_c: cover property (state_reg == OSMC_ST_WAIT ##1 state_reg == OSMC_ST_RUN);
	warm_seen_c: cover property (state_reg == OSMC_ST_BOOT && ret_valid_reg ##1 state_reg == OSMC_ST_RUN);
	hold_seen_c: cover property (state_reg == OSMC_ST_RUN ##1 state_reg == OSMC_ST_HOLD);
	block_seen_c: cover property (state_reg == OSMC_ST_BLOCK);
	ovf_seen_c: cover property ($rose(ovf_reg));

endmodule : osmc_top

// ===== osmc_master_model.sv
// Fieldbus master model: writes the control image and strobes exchange cycles
`timescale 1ns/1ps
module osmc_master_model
	import osmc_pkg::*;
(
	input  wire logic                   clk_i,       // Station clock
	input  wire logic [OSMC_IMG_W-1:0]  feedback_i,  // Feedback image from the station
	output logic                        wr_o,        // Byte write strobe
	output logic      [1:0]             addr_o,      // Byte index
	output logic      [OSMC_BYTE_W-1:0] data_o,      // Byte value
	output logic                        wr_all_o,    // Consistent write strobe
	output logic      [OSMC_IMG_W-1:0]  image_o,     // Consistent image
	output logic                        exch_o,      // Exchange cycle strobe
	output logic                        cfg_ok_o     // Feedback matches what was written
);
	logic [OSMC_IMG_W-1:0] sent_reg;  // Last control image written

	// Trust the station only on an exact bit match
	assign cfg_ok_o = (feedback_i === sent_reg);

	// Idle values at time zero
	initial begin
		wr_o = 1'b0;
		addr_o = 2'h0;
		data_o = 8'h00;
		wr_all_o = 1'b0;
		image_o = 24'h000000;
		exch_o = 1'b0;
		sent_reg = 24'h000000;
	end

	// Step to just after the next rising edge
	task edge_wait();
		@(posedge clk_i);
		#2;
	endtask : edge_wait

	// One byte write; the released data lines show the inverse, not a stale copy
	task put_byte(input logic [1:0] b, input logic [7:0] v);
		edge_wait();
		wr_o = 1'b1;
		addr_o = b;
		data_o = v;
		sent_reg[8*b +: 8] = v;
		edge_wait();
		wr_o = 1'b0;
		data_o = ~v;
	endtask : put_byte

	// Consistent three-byte write
	task put_all(input logic [23:0] img);
		edge_wait();
		wr_all_o = 1'b1;
		image_o = img;
		sent_reg = img;
		edge_wait();
		wr_all_o = 1'b0;
		image_o = ~img;
	endtask : put_all

	// Higher bytes first, the byte with the validity bits last
	task put_split(input logic [23:0] img);
		put_byte(2'h2, img[23:16]);
		put_byte(2'h1, img[15:8]);
		put_byte(2'h0, img[7:0]);
	endtask : put_split

	// One data exchange cycle
	task exchange();
		edge_wait();
		exch_o = 1'b1;
		edge_wait();
		exch_o = 1'b0;
	endtask : exchange
endmodule : osmc_master_model

// ===== tb.sv
// Self-checking testbench for the option slot mask control block
`timescale 1ns/1ps
module tb;
	import osmc_pkg::*;
	localparam logic [15:0] MASK_A = 16'h00b5;  // First station option
	localparam logic [15:0] MASK_B = 16'h00b7;  // Second option, slot 3 added
	logic        clk, rst, por, wr, wr_all, exch, online, mm_en, acc_req, cfg_ok;
	logic        io_en, subst, dnm, dwm, dtop, st3, mled, bled, adone, aerr;
	logic [1:0]  addr;
	logic [7:0]  data;
	logic [4:0]  acc_slot;
	logic [15:0] avail, ok, wrong, slot_led, code;
	logic [23:0] image, fb, ctrl;
	int          bad_count, checks, cycles;

	// 20 MHz station clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	osmc_top osmc_top_inst (.CLOCK_I(clk), .RST_I(rst), .POR_I(por), .CTRL_WR_I(wr),
		.CTRL_ADDR_I(addr), .CTRL_DATA_I(data), .CTRL_WR_ALL_I(wr_all), .CTRL_IMAGE_I(image),
		.EXCH_CYCLE_I(exch), .HOST_ONLINE_I(online), .MISMATCH_OP_EN_I(mm_en),
		.MOD_AVAIL_I(avail), .MOD_OK_I(ok), .MOD_WRONG_I(wrong), .ACC_REQ_I(acc_req),
		.ACC_SLOT_I(acc_slot), .FEEDBACK_O(fb), .CTRL_IMAGE_O(ctrl), .IO_EN_O(io_en),
		.SUBST_O(subst), .DIAG_NO_MODULE_O(dnm), .DIAG_WRONG_MODULE_O(dwm),
		.DIAG_ID_TOP_O(dtop), .STATUS1_BIT3_O(st3), .MOD_FAULT_LED_O(mled),
		.BUS_FAULT_LED_O(bled), .SLOT_FAULT_LED_O(slot_led), .ACC_DONE_O(adone),
		.ACC_ERR_O(aerr), .ACC_CODE_O(code));

	osmc_master_model osmc_master_model_inst (.clk_i(clk), .feedback_i(fb), .wr_o(wr),
		.addr_o(addr), .data_o(data), .wr_all_o(wr_all), .image_o(image), .exch_o(exch),
		.cfg_ok_o(cfg_ok));

	// Cut a hang short; the whole run needs well under 2000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end

	// Full control image for a presence mask with both validity bits set
	function automatic logic [23:0] img_of(input logic [15:0] m);
		return {6'h00, m, 2'h3};
	endfunction : img_of

	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step

	task chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for the I/O enable to reach a level
	task wait_io(input logic exp);
		for (int i = 0; i < 8 && io_en !== exp; i++) step(1);
		chk(24'(io_en), 24'(exp));
	endtask : wait_io

	// One instruction access, judged on its answer pulse
	task access(input logic [4:0] s, input logic e, input logic [15:0] c);
		acc_req = 1'b1;
		acc_slot = s;
		step(1);
		acc_req = 1'b0;
		for (int i = 0; i < 4 && adone !== 1'b1; i++) step(1);
		chk(24'({adone, aerr, code}), 24'({1'b1, e, c}));
		step(1);
	endtask : access

	// Waiting for option data: I/O off, bus fault dark even offline
	task t_first_start();
		online = 1'b0;
		step(3);
		chk(24'({bled, slot_led}), 24'({1'b0, 16'hffff}));
		chk(24'({io_en, subst}), 24'h1);
		online = 1'b1;
		osmc_master_model_inst.exchange();
		chk(fb, {6'h00, MASK_A, 2'h0});
	endtask : t_first_start

	// Image first with validity cleared, validity set afterwards
	task t_staged();
		osmc_master_model_inst.put_all(img_of(MASK_A) & ~24'h1);
		osmc_master_model_inst.exchange();
		chk(24'({fb[1:0], io_en}), 24'h0);
		osmc_master_model_inst.put_byte(2'h0, {MASK_A[5:0], 2'h3});
		wait_io(1'b1);
		osmc_master_model_inst.exchange();
		chk(fb, img_of(MASK_A));
		chk(24'(cfg_ok), 24'h1);
	endtask : t_staged

	// A module that is not OK drops out of the next feedback
	task t_status();
		ok = ~16'h0001;
		osmc_master_model_inst.exchange();
		chk(fb, img_of(MASK_A) & ~24'h4);
		chk(24'(slot_led), 24'h000001);
		ok = 16'hffff;
		osmc_master_model_inst.exchange();
		chk(fb, img_of(MASK_A));
	endtask : t_status

	// Absent, present, beyond-range and head slots, back to back
	task t_access();
		access(5'h03, 1'b1, OSMC_ERR_ABSENT);
		access(5'h02, 1'b0, OSMC_ERR_NONE);
		access(5'h12, 1'b1, OSMC_ERR_ABSENT);
		access(5'h00, 1'b0, OSMC_ERR_NONE);
	endtask : t_access

	// New option with one more slot; I/O waits for the module to appear
	task t_reconfig();
		osmc_master_model_inst.put_split(img_of(MASK_B));
		chk(ctrl, img_of(MASK_B));
		wait_io(1'b0);
		avail = MASK_B;
		wait_io(1'b1);
	endtask : t_reconfig

	// Warm restart runs at once from the retained option data
	task t_warm();
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		wait_io(1'b1);
		osmc_master_model_inst.exchange();
		chk(fb, img_of(MASK_B));
	endtask : t_warm

	// Mismatch not tolerated: missing, then wrong module
	task t_block();
		mm_en = 1'b0;
		avail = MASK_B & ~16'h0001;
		wait_io(1'b0);
		step(2);
		chk(24'({dnm, dwm, subst, mled}), 24'hb);
		avail = MASK_B;
		wait_io(1'b1);
		wrong = 16'h0001;
		wait_io(1'b0);
		step(2);
		chk(24'({dnm, dwm}), 24'h1);
		wrong = 16'h0000;
		wait_io(1'b1);
		mm_en = 1'b1;
	endtask : t_block

	// More modules plugged than the option allows
	task t_overflow();
		avail = 16'hffff;
		wait_io(1'b0);
		step(2);
		chk(24'({dtop, st3, mled}), 24'h7);
		avail = MASK_B;
		wait_io(1'b1);
		chk(24'({dtop, st3, mled}), 24'h0);
	endtask : t_overflow

	// Without the master the view is gapless from the lowest slot
	task t_offline();
		online = 1'b0;
		osmc_master_model_inst.exchange();
		chk(fb, {6'h00, 16'h003f, 2'h3});
		chk(24'(bled), 24'h1);
		online = 1'b1;
		osmc_master_model_inst.exchange();
		chk(fb, img_of(MASK_B));
	endtask : t_offline

	task test_done();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done

	// Reset both kinds for 12 cycles, then run every scenario
	initial begin
		bad_count = 0;
		checks = 0;
		cycles = 0;
		rst = 1'b1;
		por = 1'b1;
		online = 1'b1;
		mm_en = 1'b1;
		avail = MASK_A;
		ok = 16'hffff;
		wrong = 16'h0000;
		acc_req = 1'b0;
		acc_slot = 5'h00;
		step(12);
		rst = 1'b0;
		por = 1'b0;
		t_first_start();
		t_staged();
		t_status();
		t_access();
		t_reconfig();
		t_warm();
		t_block();
		t_overflow();
		t_offline();
		test_done();
	end
endmodule : tb
